// ---- rtl/plm_defs.vh ----
// Purpose: Shared constants for the link and mode control block
// Assumes: 100 MHz core clock
// Notes:   Offsets are byte addresses on a 32-bit Avalon-MM slave
`ifndef PLM_DEFS_VH
`define PLM_DEFS_VH

// ==========================================================
// Register offsets
`define PLM_OFS_CTRL     4'h0
`define PLM_OFS_STATUS   4'h4
`define PLM_OFS_STATOUT  4'h8
`define PLM_OFS_REMOTE   4'hC

// ==========================================================
// Control register fields
`define PLM_C_NEGOTIATION_STRAP_PIN_EN    0
`define PLM_C_NEGOTIATION_STRAP_PIN_RST   1
`define PLM_C_SPEED      2
`define PLM_C_DUPLEX     3
`define PLM_C_LINK_DIS   4
`define PLM_C_APOL_DIS   5
`define PLM_CTRL_RST     6'h01

// ==========================================================
// Status fields (status and status output share layout)
`define PLM_S_LINK       0
`define PLM_S_ACK        1
`define PLM_S_JABBER     2
`define PLM_S_SPEED      3
`define PLM_S_DUPLEX     4
`define PLM_S_REVPOL     5

// ==========================================================
// Advertisement and ability bits
`define PLM_ADV_RST      16'h01E1
`define PLM_AB_10HD      5
`define PLM_AB_10FD      6
`define PLM_AB_100HD     7
`define PLM_AB_100FD     8

// ==========================================================
// Timing
`define PLM_CLK_MHZ      100
`define PLM_BREAK_MS     1200
`define PLM_LOSS_MS      50
`define PLM_JAB_MS       20
`define PLM_UNJAB_MS     250

`endif

// ---- rtl/plm_link_ctrl.v ----
// Purpose: Per-channel link integrity, negotiation and mode control
// Assumes: Line front end delivers decoded pulse events on this clock
// Notes:   Avalon-MM slave, one wait state per access
//
// Contract
// - Reset, restart or link fail start negotiation
// - Negotiation needs control bit and strap high
// - Enable or restart: silent break, then negotiate
// - Forced mode: speed and duplex from control
// - Restart bit launches negotiation at once
// - Plain partner signal selects matching mode
// - Partner bursts: send our advertisement word
// - Partner word stored in remote register
// - Burst word is sixteen bits wide
// - Priority resolution sets speed, duplex, integrity
// - Result shown in speed and duplex bits
// - Acknowledge bit shows negotiation progress
// - 10M: send and use normal link pulses
// - 100M: link from squelch and descrambler lock
// - Link bits and indicator follow link pass
// - Link disable forces pass and control modes
// - No jabber detection at 100M
// - 10M jabber: idle line, collision, status bits
// - Bad idle pulse polarity sets bit, inverts
// - Full duplex: no collision except in jabber, no carrier loopback
// - Forced duplex from control bit or strap
// - Duplex bit and indicator one show full
//
// Chosen here: the register addresses and the Avalon-MM register port.
`include "plm_defs.vh"

module plm_link_ctrl #(
    parameter BREAK_CYC = `PLM_BREAK_MS * 1000 * `PLM_CLK_MHZ,
    parameter LOSS_CYC  = `PLM_LOSS_MS * 1000 * `PLM_CLK_MHZ,
    parameter JAB_CYC   = `PLM_JAB_MS * 1000 * `PLM_CLK_MHZ,
    parameter UNJAB_CYC = `PLM_UNJAB_MS * 1000 * `PLM_CLK_MHZ,
    parameter [15:0] ADV_RST = `PLM_ADV_RST
) (
    input  wire        clock,                 // Core clock
    input  wire        reset,                 // Sync reset, high
    input  wire        ce,                    // Clock enable
    input  wire [3:0]  address,               // Avalon byte address
    input  wire        read,                  // Avalon read
    input  wire        write,                 // Avalon write
    input  wire [31:0] writedata,             // Avalon write data
    output reg  [31:0] readdata,              // Avalon read data
    output reg         waitrequest,           // Avalon wait
    input  wire        negotiation_strap_pin, // Negotiation strap
    input  wire        duplex_strap_pin,      // Forced duplex strap
    input  wire        rx_nlp,                // Normal link pulse seen
    input  wire        rx_flp_valid,          // Burst word received
    input  wire [15:0] rx_flp_word,           // Received burst word
    input  wire        rx_100_ok,             // Squelch and lock good
    input  wire        rx_activity,           // Receive carrier
    input  wire        soi_seen,              // Start of idle pulse seen
    input  wire        soi_pol_bad,           // That pulse was inverted
    input  wire        tx_en,                 // MAC transmit enable
    output reg         tx_quiet,              // Halt all transmission
    output reg         tx_send_nlp,           // Send normal link pulses
    output reg         tx_send_flp,           // Send burst word
    output reg  [15:0] tx_flp_word,           // Word to send
    output reg         tx_force_idle,         // Jabber idle force
    output reg         link_pass,             // Link pass state
    output reg         speed_100,             // 100M mode
    output reg         full_duplex,           // Full duplex mode
    output reg         col_out,               // Collision
    output reg         crs_loop,              // Transmit to carrier loop
    output reg         rx_invert,             // Invert receive data
    output reg         indicator_link_n,      // Low in link pass
    output reg         indicator_pin_one_n    // Low in full duplex
);
    // ==========================================================
    // States
    localparam [2:0] ST_BREAK = 3'd0;
    localparam [2:0] ST_ABIL  = 3'd1;
    localparam [2:0] ST_CHECK = 3'd2;
    localparam [2:0] ST_PASS  = 3'd3;
    localparam [2:0] ST_FAIL  = 3'd4;

    // ==========================================================
    // Priority resolution: {found, speed100, full}
    function [2:0] resolve;
        input [15:0] a;
        input [15:0] b;
        reg   [15:0] c;
        begin
            c = a & b;
            if (c[`PLM_AB_100FD])
                resolve = 3'b111;
            else if (c[`PLM_AB_100HD])
                resolve = 3'b110;
            else if (c[`PLM_AB_10FD])
                resolve = 3'b101;
            else if (c[`PLM_AB_10HD])
                resolve = 3'b100;
            else
                resolve = 3'b000;
        end
    endfunction

    // ==========================================================
    // Registers
    reg  [2:0]  state_q;
    reg  [5:0]  ctrl_q;
    reg  [15:0] adv_q;
    reg  [15:0] remote_q;
    reg         neg_speed_q;
    reg         neg_full_q;
    reg         ack_q;
    reg         jab_q;
    reg         jab_sticky_q;
    reg         revpol_q;
    reg         negotiation_strap_pin_on_q;
    reg         restart_q;
    reg  [1:0]  settle_q;

    wire        negotiation_strap_pin_strap_s;
    wire        duplex_strap_pin_strap_s;
    wire        brk_done;
    wire        loss_done;
    wire        jab_done;
    wire        unjab_done;
    wire [2:0]  res;
    wire        negotiation_strap_pin_on;
    wire        lnk_dis;
    wire        spd;
    wire        fdx;
    wire        lnk;
    wire        acc;
    wire        wr_ctrl;

    plm_sync #(.W(2)) u_sync (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .d     ({negotiation_strap_pin, duplex_strap_pin}),
        .q     ({negotiation_strap_pin_strap_s, duplex_strap_pin_strap_s})
    );

    assign negotiation_strap_pin_on = ctrl_q[`PLM_C_NEGOTIATION_STRAP_PIN_EN] & negotiation_strap_pin_strap_s;
    assign lnk_dis = ctrl_q[`PLM_C_LINK_DIS];
    assign res     = resolve(adv_q, rx_flp_word);
    assign spd     = (lnk_dis | !negotiation_strap_pin_on) ? ctrl_q[`PLM_C_SPEED]
                                          : neg_speed_q;
    assign fdx     = (lnk_dis | !negotiation_strap_pin_on)
                   ? (ctrl_q[`PLM_C_DUPLEX] | duplex_strap_pin_strap_s)
                   : neg_full_q;
    assign lnk     = lnk_dis | (state_q == ST_PASS);
    assign acc     = (read | write) & waitrequest;
    assign wr_ctrl = acc & write & (address == `PLM_OFS_CTRL);

    // ==========================================================
    // Timers
    plm_timer #(.LIMIT(BREAK_CYC)) u_brk (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .run   (state_q == ST_BREAK),
        .done  (brk_done)
    );

    // No pulse or carrier for the loss time drops a 10M link
    plm_timer #(.LIMIT(LOSS_CYC)) u_loss (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .run   ((state_q == ST_CHECK || state_q == ST_PASS) && !spd
                && !rx_nlp && !rx_activity),
        .done  (loss_done)
    );

    plm_timer #(.LIMIT(JAB_CYC)) u_jab (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .run   (tx_en & !spd & !jab_q),
        .done  (jab_done)
    );

    plm_timer #(.LIMIT(UNJAB_CYC)) u_unjab (
        .clock (clock),
        .reset (reset),
        .ce    (ce),
        .run   (jab_q & !tx_en),
        .done  (unjab_done)
    );

    // ==========================================================
    // Negotiation and link state machine
    always @(posedge clock) begin
        if (reset) begin
            state_q     <= ST_BREAK;
            remote_q    <= 16'h0000;
            neg_speed_q <= 1'b0;
            neg_full_q  <= 1'b0;
            ack_q       <= 1'b0;
            negotiation_strap_pin_on_q   <= 1'b0;
            settle_q    <= 2'h0;
        end else if (ce) begin
            negotiation_strap_pin_on_q <= negotiation_strap_pin_on;
            // Synced straps read low for two edges after reset
            if (settle_q != 2'h2)
                settle_q <= settle_q + 2'h1;
            if (restart_q || (negotiation_strap_pin_on && !negotiation_strap_pin_on_q)) begin
                state_q <= ST_BREAK;
                ack_q   <= 1'b0;
            end else begin
                case (state_q)
                    ST_BREAK: begin
                        // No skip before straps settle: it would cut the break
                        if (!negotiation_strap_pin_on && settle_q == 2'h2)
                            state_q <= ST_CHECK;
                        else if (brk_done)
                            state_q <= ST_FAIL;
                    end
                    ST_ABIL: begin
                        if (!negotiation_strap_pin_on) begin
                            state_q <= ST_CHECK;
                        end else if (rx_flp_valid) begin
                            remote_q <= rx_flp_word;
                            if (res[2]) begin
                                neg_speed_q <= res[1];
                                neg_full_q  <= res[0];
                                ack_q       <= 1'b1;
                                state_q     <= ST_CHECK;
                            end
                        end else if (rx_100_ok) begin
                            neg_speed_q <= 1'b1;
                            neg_full_q  <= 1'b0;
                            state_q     <= ST_CHECK;
                        end else if (rx_nlp) begin
                            neg_speed_q <= 1'b0;
                            neg_full_q  <= 1'b0;
                            state_q     <= ST_CHECK;
                        end
                    end
                    ST_CHECK: begin
                        if (spd ? rx_100_ok : rx_nlp)
                            state_q <= ST_PASS;
                        else if (!spd && loss_done)
                            state_q <= ST_FAIL;
                    end
                    ST_PASS: begin
                        if (spd ? !rx_100_ok : loss_done)
                            state_q <= ST_FAIL;
                    end
                    ST_FAIL: begin
                        ack_q   <= 1'b0;
                        state_q <= negotiation_strap_pin_on ? ST_ABIL : ST_CHECK;
                    end
                    default: state_q <= ST_BREAK;
                endcase
            end
        end
    end

    // ==========================================================
    // Jabber and polarity
    always @(posedge clock) begin
        if (reset) begin
            jab_q        <= 1'b0;
            jab_sticky_q <= 1'b0;
            revpol_q     <= 1'b0;
        end else if (ce) begin
            if (spd)
                jab_q <= 1'b0;
            else if (jab_done)
                jab_q <= 1'b1;
            else if (unjab_done)
                jab_q <= 1'b0;
            // Set wins over the clear-on-read
            if (jab_q && !spd)
                jab_sticky_q <= 1'b1;
            else if (acc && read && address == `PLM_OFS_STATUS)
                jab_sticky_q <= 1'b0;
            if (spd)
                revpol_q <= 1'b0;
            else if (soi_seen)
                revpol_q <= soi_pol_bad;
        end
    end

    // ==========================================================
    // Avalon-MM slave: request answered one cycle after it rises
    always @(posedge clock) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
            ctrl_q      <= `PLM_CTRL_RST;
            adv_q       <= ADV_RST;
            restart_q   <= 1'b0;
        end else if (ce) begin
            waitrequest <= !acc;
            restart_q   <= wr_ctrl & writedata[`PLM_C_NEGOTIATION_STRAP_PIN_RST];
            if (wr_ctrl)
                ctrl_q <= writedata[5:0] & 6'h3D;
            if (acc && write && address == `PLM_OFS_REMOTE)
                adv_q <= writedata[15:0];
            if (acc && read) begin
                case (address)
                    `PLM_OFS_CTRL:    readdata <= {26'h000_0000, ctrl_q};
                    `PLM_OFS_STATUS:  readdata <= {29'h0000_0000,
                                                   jab_sticky_q, ack_q, lnk};
                    `PLM_OFS_STATOUT: readdata <= {26'h000_0000, revpol_q,
                                                   fdx, spd, jab_q,
                                                   ack_q, lnk};
                    `PLM_OFS_REMOTE:  readdata <= {adv_q, remote_q};
                    default:          readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Registered outputs
    always @(posedge clock) begin
        if (reset) begin
            tx_quiet            <= 1'b1;
            tx_send_nlp         <= 1'b0;
            tx_send_flp         <= 1'b0;
            tx_flp_word         <= 16'h0000;
            tx_force_idle       <= 1'b0;
            link_pass           <= 1'b0;
            speed_100           <= 1'b0;
            full_duplex         <= 1'b0;
            col_out             <= 1'b0;
            crs_loop            <= 1'b0;
            rx_invert           <= 1'b0;
            indicator_link_n    <= 1'b1;
            indicator_pin_one_n <= 1'b1;
        end else if (ce) begin
            tx_quiet    <= !lnk_dis && state_q == ST_BREAK;
            tx_send_flp <= !lnk_dis && state_q == ST_ABIL;
            tx_flp_word <= adv_q;
            tx_send_nlp <= !spd && (lnk_dis || state_q == ST_CHECK
                           || state_q == ST_PASS);
            tx_force_idle <= jab_q;
            link_pass   <= lnk;
            speed_100   <= spd;
            full_duplex <= fdx;
            col_out     <= jab_q | (!fdx && lnk && tx_en
                           && rx_activity);
            crs_loop    <= tx_en && !fdx && lnk && !jab_q;
            rx_invert   <= revpol_q & !ctrl_q[`PLM_C_APOL_DIS];
            indicator_link_n    <= !lnk;
            indicator_pin_one_n <= !fdx;
        end
    end
endmodule // plm_link_ctrl

// ---- rtl/plm_sync.v ----
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
module plm_sync #(
    parameter W = 1
) (
    input  wire         clock,   // Core clock
    input  wire         reset,   // Sync reset
    input  wire         ce,      // Clock enable
    input  wire [W-1:0] d,       // Async input
    output reg  [W-1:0] q        // Synchronised level
);
    reg [W-1:0] meta_q;

    always @(posedge clock) begin
        if (reset) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // plm_sync

// ---- rtl/plm_timer.v ----
// Purpose: Run-while-high interval timer
// Assumes: LIMIT at least 1
// Notes:   Clears whenever run drops; done saturates
module plm_timer #(
    parameter LIMIT = 32'd100
) (
    input  wire clock,   // Core clock
    input  wire reset,   // Sync reset
    input  wire ce,      // Clock enable
    input  wire run,     // Count while high
    output reg  done     // Interval elapsed
);
    reg [31:0] cnt_q;

    always @(posedge clock) begin
        if (reset) begin
            cnt_q <= 32'h0000_0000;
            done  <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_q <= 32'h0000_0000;
                done  <= 1'b0;
            end else if (cnt_q >= LIMIT - 32'd1) begin
                done  <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 32'd1;
            end
        end
    end
endmodule // plm_timer

// ---- testbench/plm_link_props.sv ----
// Purpose: Port assertions for the link control block
// Assumes: Bench holds ce high
// Notes:   Bound to every plm_link_ctrl instance
module plm_link_props #(
    parameter JAB_CYC = 50
) (
    input wire        clock,                 // Clock
    input wire        reset,                 // Reset
    input wire        ce,                    // Enable
    input wire [3:0]  address,               // Bus address
    input wire        read,                  // Bus read
    input wire        write,                 // Bus write
    input wire [31:0] writedata,             // Bus data
    input wire        waitrequest,           // Bus wait
    input wire        negotiation_strap_pin, // Strap
    input wire        tx_en,                 // Transmit enable
    input wire        tx_quiet,              // Break
    input wire        tx_send_nlp,           // Link pulses
    input wire        tx_send_flp,           // Bursts
    input wire        tx_force_idle,         // Jabber idle
    input wire        link_pass,             // Link
    input wire        speed_100,             // Speed
    input wire        full_duplex,           // Duplex
    input wire        col_out,               // Collision
    input wire        crs_loop,              // Loopback
    input wire        indicator_link_n,      // Link lamp
    input wire        indicator_pin_one_n    // Duplex lamp
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // ==========================================================
    // Jabber length counter
    logic [15:0] jab_cnt_q;
    always_ff @(posedge clock) begin
        if (reset || !(tx_en && link_pass && !speed_100))
            jab_cnt_q <= 16'h0000;
        else if (jab_cnt_q < 16'hFFFF)
            jab_cnt_q <= jab_cnt_q + 16'h0001;
    end

    // ==========================================================
    // Assertions
    a_bus_one_wait: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_bus_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("wait low too long");
    a_quiet_mute: assert property (tx_quiet |-> !tx_send_nlp && !tx_send_flp)
        else $error("pulses during break");
    a_restart_go: assert property (ce && write && waitrequest && address == 4'h0
        && writedata[1] && writedata[0] && !writedata[4] && negotiation_strap_pin
        |-> ##[1:4] tx_quiet)
        else $error("restart ignored");
    a_link_lamp: assert property (indicator_link_n == !link_pass)
        else $error("link lamp wrong");
    a_fdx_lamp: assert property (indicator_pin_one_n == !full_duplex)
        else $error("duplex lamp wrong");
    a_fdx_no_loop: assert property (full_duplex |-> !crs_loop)
        else $error("loopback in full duplex");
    a_fdx_no_col: assert property (full_duplex && !tx_force_idle && !$past(tx_force_idle)
        |-> !col_out)
        else $error("collision in full duplex");
    a_jab_col: assert property (tx_force_idle |-> col_out)
        else $error("jabber without collision");
    a_jab_fast: assert property (speed_100 && $past(speed_100) |-> !tx_force_idle)
        else $error("jabber at 100M");
    a_jab_time: assert property (jab_cnt_q == JAB_CYC + 3 |-> tx_force_idle)
        else $error("jabber not detected");
endmodule // plm_link_props

bind plm_link_ctrl plm_link_props #(.JAB_CYC(JAB_CYC)) plm_link_props_i (
    .clock(clock), .reset(reset), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .negotiation_strap_pin(negotiation_strap_pin), .tx_en(tx_en),
    .tx_quiet(tx_quiet), .tx_send_nlp(tx_send_nlp), .tx_send_flp(tx_send_flp),
    .tx_force_idle(tx_force_idle), .link_pass(link_pass), .speed_100(speed_100),
    .full_duplex(full_duplex), .col_out(col_out), .crs_loop(crs_loop),
    .indicator_link_n(indicator_link_n), .indicator_pin_one_n(indicator_pin_one_n));

// ---- testbench/plm_partner.sv ----
// Purpose: Remote link partner on the twisted pair
// Assumes: Mode 0 silent, 1 plain 10M, 2 bursts, 3 plain 100M
// Notes:   Word lines toggle between bursts, never hold stale data
module plm_partner (
    input  wire logic        clock,        // Clock
    input  wire logic        reset,        // Reset
    input  wire logic [1:0]  mode,         // Signal kind
    input  wire logic [15:0] word,         // Ability word
    output logic             rx_nlp,       // Link pulse
    output logic             rx_flp_valid, // Burst done
    output logic      [15:0] rx_flp_word,  // Burst word
    output logic             rx_100_ok,    // 100M signal
    output logic             rx_activity   // Carrier
);
    logic [4:0] tick_q;
    always @(posedge clock) begin
        if (reset) begin
            tick_q <= 5'h00;
            rx_nlp <= 1'b0;
            rx_flp_valid <= 1'b0;
            rx_flp_word <= 16'h0000;
            rx_100_ok <= 1'b0;
            rx_activity <= 1'b0;
        end else begin
            tick_q <= tick_q + 5'h01;
            rx_nlp <= mode == 2'h1 && tick_q == 5'h1F;
            rx_flp_valid <= mode == 2'h2 && tick_q[3:0] == 4'hF;
            // Whole 16-bit word per burst
            rx_flp_word <= (mode == 2'h2 && tick_q[3:0] == 4'hF) ? word : ~rx_flp_word;
            rx_100_ok <= mode == 2'h3;
            rx_activity <= mode == 2'h3;
        end
    end
endmodule // plm_partner

// ---- testbench/tb.sv ----
// Purpose: Register and link scenarios for plm_link_ctrl
// Assumes: Shortened break, loss and jabber intervals
// Notes:   Partner model supplies line events
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam BRK = 200, JAB = 50, UNJAB = 80;
    logic clock = 1'b0, reset = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0;
    logic nsp = 1'b1, dsp = 1'b0, start_of_idle_pulse = 1'b0, bad = 1'b0, tx_en = 1'b0;
    logic [3:0] address = 4'h0;
    logic [1:0] mode = 2'h0;
    logic [31:0] writedata = 32'h0000_0000, readdata, rd;
    logic [15:0] fw, tfw;
    logic wr, quiet, nlp, flp, fidle, lp, s100, fd, col, loop, inv, lk_n, one_n, fv, ok, act;
    logic snlp;
    int err_total = 0, n_compared = 0, n;

    always #5 clock = ~clock;

    plm_link_ctrl #(.BREAK_CYC(BRK), .LOSS_CYC(100), .JAB_CYC(JAB), .UNJAB_CYC(UNJAB))
    plm_link_ctrl_i (.clock(clock), .reset(reset), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(wr),
        .negotiation_strap_pin(nsp), .duplex_strap_pin(dsp), .rx_nlp(nlp),
        .rx_flp_valid(fv), .rx_flp_word(fw), .rx_100_ok(ok), .rx_activity(act),
        .soi_seen(start_of_idle_pulse), .soi_pol_bad(bad), .tx_en(tx_en), .tx_quiet(quiet),
        .tx_send_nlp(snlp), .tx_send_flp(flp), .tx_flp_word(tfw), .tx_force_idle(fidle),
        .link_pass(lp), .speed_100(s100), .full_duplex(fd), .col_out(col),
        .crs_loop(loop), .rx_invert(inv), .indicator_link_n(lk_n),
        .indicator_pin_one_n(one_n));
    plm_partner plm_partner_i (.clock(clock), .reset(reset), .mode(mode),
        .word(16'h0101), .rx_nlp(nlp), .rx_flp_valid(fv), .rx_flp_word(fw),
        .rx_100_ok(ok), .rx_activity(act));

    task chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t bit %b expected %b", $time, g, e);
        end
    endtask
    task chkw(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t word %h expected %h", $time, g, e);
        end
    endtask
    // Holds the request until wait is seen low at an edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do begin
            @(posedge clock);
            k++;
        end while (wr !== 1'b0 && k < 50);
        rd = readdata;
        if (k >= 50) chk1(1'b0, 1'b1);
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task poll(input logic [3:0] a, input int b);
        int k;
        k = 0;
        do begin
            bus(1'b0, a, 32'h0000_0000);
            k++;
        end while (rd[b] !== 1'b1 && k < 100);
        chk1(rd[b], 1'b1);
    endtask
    function logic sig(input int s);
        case (s)
            0: return lp;
            1: return quiet;
            default: return fidle;
        endcase
    endfunction
    task wait_on(input int s, input logic v);
        n = 0;
        while (sig(s) !== v && n < 2000) begin
            @(posedge clock);
            n++;
        end
        chk1(sig(s), v);
    endtask
    task pulse_soi;
        start_of_idle_pulse <= 1'b1;
        bad <= 1'b1;
        @(posedge clock);
        start_of_idle_pulse <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task results;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clock);
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        wait_on(1, 1'b0);
        chk1(n >= BRK - 2 && n <= BRK + 8, 1'b1);
        bus(1'b0, 4'h0, 32'h0000_0000);
        chkw(rd, 32'h0000_0001);
        bus(1'b0, 4'h2, 32'h0000_0000);
        chkw(rd, 32'h0000_0000);
        chk1(flp, 1'b1);
        mode <= 2'h2;
        poll(4'h8, 1);
        chkw({16'h0000, tfw}, 32'h0000_01E1);
        bus(1'b0, 4'hC, 32'h0000_0000);
        chkw(rd, 32'h01E1_0101);
        mode <= 2'h3;
        wait_on(0, 1'b1);
        bus(1'b0, 4'h8, 32'h0000_0000);
        chkw(rd & 32'h0000_001B, 32'h0000_001B);
        chk1(lk_n, 1'b0);
        chk1(one_n, 1'b0);
        mode <= 2'h0;
        wait_on(0, 1'b0);
        mode <= 2'h3;
        wait_on(0, 1'b1);
        chk1(s100, 1'b1);
        chk1(fd, 1'b0);
        bus(1'b1, 4'h0, 32'h0000_0003);
        wait_on(1, 1'b1);
        chk1(n <= 4, 1'b1);
        mode <= 2'h1;
        wait_on(1, 1'b0);
        wait_on(0, 1'b1);
        chk1(s100, 1'b0);
        chk1(snlp, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0000);
        dsp <= 1'b1;
        repeat (8) @(posedge clock);
        chk1(fd, 1'b1);
        dsp <= 1'b0;
        bus(1'b1, 4'h0, 32'h0000_0008);
        repeat (8) @(posedge clock);
        chk1(fd, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0000);
        repeat (8) @(posedge clock);
        chk1(fd, 1'b0);
        wait_on(0, 1'b1);
        tx_en <= 1'b1;
        wait_on(2, 1'b1);
        chk1(n >= JAB - 2 && n <= JAB + 6, 1'b1);
        chk1(col, 1'b1);
        poll(4'h4, 2);
        tx_en <= 1'b0;
        wait_on(2, 1'b0);
        chk1(n >= UNJAB - 2 && n <= UNJAB + 6, 1'b1);
        pulse_soi();
        chk1(inv, 1'b1);
        poll(4'h8, 5);
        bus(1'b1, 4'h0, 32'h0000_0020);
        pulse_soi();
        chk1(inv, 1'b0);
        mode <= 2'h0;
        bus(1'b1, 4'h0, 32'h0000_001C);
        // Mode outputs are registered after the control write
        repeat (4) @(posedge clock);
        wait_on(0, 1'b1);
        chk1(s100 & fd & !quiet, 1'b1);
        tx_en <= 1'b1;
        repeat (JAB + 20) @(posedge clock);
        chk1(fidle, 1'b0);
        tx_en <= 1'b0;
        results();
    end
endmodule // tb
